// ### bdvp_pkg.sv
// constants and state type for the bias converter value pipeline
package bdvp_pkg;
    localparam int          NCH             = 8;
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          FAST_STEP_NS    = 50;
    localparam int          FAST_CYC        = (FAST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          BOOST_UNIT_NS   = 1000;
    localparam int          BOOST_UNIT_CYC  = (BOOST_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RAMP_T0_NS      = 50;
    localparam int          RAMP_T1_NS      = 1000;
    localparam int          RAMP_T2_NS      = 5000;
    localparam int          RAMP_T3_NS      = 10000;
    localparam int          RAMP_T4_NS      = 100000;
    localparam int          RAMP_T5_NS      = 250000;
    localparam int          RAMP_T6_NS      = 1000000;
    localparam int          RAMP_T7_NS      = 4000000;
    localparam int          RAMP_C0         = (RAMP_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RAMP_C1         = (RAMP_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RAMP_C2         = (RAMP_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RAMP_C3         = (RAMP_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RAMP_C4         = (RAMP_T4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RAMP_C5         = (RAMP_T5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RAMP_C6         = (RAMP_T6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RAMP_C7         = (RAMP_T7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0]  TEMP_LOW_POINT  = 9'h035;
    localparam logic [8:0]  TEMP_REF_POINT  = 9'h08D;
    localparam logic [8:0]  TEMP_SPAN_MAX   = 9'h0FF;
    localparam int          SEG_COUNTS      = 32;
    localparam int          GRAD_SCALE_MUL  = 49;
    localparam int          GRAD_SCALE_SHR  = 9;
    localparam logic [11:0] CODE_MAX        = 12'hFFF;
    localparam logic [11:0] CODE_MIN        = 12'h000;
    localparam logic [1:0]  SRC_RAIL        = 2'h0;
    localparam logic [1:0]  SRC_ODD         = 2'h1;
    localparam logic [1:0]  SRC_BUF         = 2'h2;
    localparam int          RB_SEL_LSB      = 12;
    localparam logic [15:0] RB_RESET        = 16'h0000;

    typedef struct packed {
        logic                   active;
        logic [17:0]            ramp_cnt;
        logic [7:0][11:0]       ramp;
        logic [7:0][7:0]        boost;
        logic [7:0][15:0]       bcnt;
        logic [7:0]             bdown;
        logic [1:0]             gate_prev;
        logic [7:0][11:0]       word;
        logic [2:0]             rb_sel;
        logic [15:0]            rb_data;
        logic [7:0]             eff_en;
        logic [7:0]             eff_rng;
        logic [7:0][1:0]        eff_ofs;
        logic [3:0]             clamped;
        logic [3:0][1:0]        src;
        logic [3:0][5:0]        drop;
    } bdvp_state_s;
endpackage

// ### bdvp_top.sv
// value pipeline from channel settings to the eight converter input words
//
// Function
// - tracking odd channel: even value plus offset
// - tracking odd uses even range and offset
// - thermal delta added only when correction on
// - eight gradients, 32-count segments from lowest point
// - gradients are signed nibbles per 8 kelvin
// - gradient 0 in top nibble, 7 lowest
// - saturate adjusted value to 000..FFF
// - odd upper limit is even ramped value under choice 1
// - ramp one count per selected interval
// - one interval code for all channels
// - code ramps from zero after enable
// - gate low: boost rises per 50ns
// - gate rise: boost falls per slope microseconds
// - slope code zero: 50ns fall steps
// - gate fall mid-decay restores full height
// - stage order track, thermal, limit, ramp, boost
// - readback select latched from bits 14:12
// - readback low twelve bits give word
// - clamp engaged selects pinch-off source on output
// - reset and startup force rail source
// - choice 0 selects reference rail
// - choice 1 selects odd neighbour
// - odd source uses even enable, range, offset
// - choice 2 or 3 selects clamp buffer
// - buffer sits drop code steps below even
`timescale 1ns/1ps
module bdvp_top
    import bdvp_pkg::*;
#(
    parameter int RAMP_CYC_5      = RAMP_C5,
    parameter int RAMP_CYC_6      = RAMP_C6,
    parameter int RAMP_CYC_7      = RAMP_C7,
    parameter int BOOST_STEP_CYC  = BOOST_UNIT_CYC
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic [7:0][11:0]    ch_value,
    input  wire logic [7:0]          ch_enable,
    input  wire logic [7:0]          ch_range,
    input  wire logic [7:0][1:0]     ch_offset,
    input  wire logic [7:0]          track_enable,
    input  wire logic [7:0][11:0]    track_offset,
    input  wire logic                thermal_correction_on,
    input  wire logic [8:0]          die_temperature,
    input  wire logic [7:0][31:0]    gradient_table,
    input  wire logic [2:0]          ramp_interval_code,
    input  wire logic [7:0]          boost_enable,
    input  wire logic [7:0][7:0]     boost_height,
    input  wire logic [7:0][7:0]     boost_slope,
    input  wire logic [1:0]          switch_gate_input,
    input  wire logic [3:0][1:0]     clamp_source_choice,
    input  wire logic [3:0][5:0]     buffer_drop_code,
    input  wire logic [3:0]          output_force,
    input  wire logic                rb_write,
    input  wire logic [15:0]         rb_wdata,
    output logic      [15:0]         rb_rdata,
    output logic      [7:0][11:0]    converter_input_word,
    output logic      [7:0]          eff_enable,
    output logic      [7:0]          eff_range,
    output logic      [7:0][1:0]     eff_offset,
    output logic      [3:0]          out_clamped,
    output logic      [3:0][1:0]     pinchoff_source,
    output logic      [3:0][5:0]     clamp_buffer_drop
);
    logic        rst_meta_q;
    logic        rst_sync_q;
    bdvp_state_s q;
    bdvp_state_s n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // signed gradient k from the packed table word
    function automatic logic signed [4:0] grad(input logic [31:0] tab, input int k);
        logic [3:0] nib;
        nib = tab[31 - 4 * k -: 4];
        return signed'({nib[3], nib});
    endfunction

    // cumulative gradient sum up to a position above the lowest point
    function automatic logic signed [19:0] accum(input logic [31:0] tab, input logic [7:0] pos);
        logic signed [19:0] acc;
        logic        [2:0]  seg;
        acc = 20'sh00000;
        seg = pos[7:5];
        for (int k = 0; k < 8; k++) begin
            if (k < int'(seg)) begin
                acc = acc + 20'(grad(tab, k) * SEG_COUNTS);
            end else if (k == int'(seg)) begin
                acc = acc + 20'(grad(tab, k) * signed'({1'b0, pos[4:0]}));
            end
        end
        return acc;
    endfunction

    // delta relative to the reference point, scaled from per-8K to per-count
    function automatic logic signed [15:0] tdelta(input logic [31:0] tab, input logic [8:0] t);
        logic        [8:0]  pos;
        logic        [8:0]  rpos;
        logic signed [19:0] diff;
        logic signed [19:0] scaled;
        pos    = (t < TEMP_LOW_POINT) ? 9'h000 : 9'(t - TEMP_LOW_POINT);
        // beyond the table the position is held at the span end, so the delta stays flat
        pos    = (pos > TEMP_SPAN_MAX) ? TEMP_SPAN_MAX : pos;
        rpos   = 9'(TEMP_REF_POINT - TEMP_LOW_POINT);
        diff   = accum(tab, pos[7:0]) - accum(tab, rpos[7:0]);
        scaled = 20'(diff * GRAD_SCALE_MUL) >>> GRAD_SCALE_SHR;
        return scaled[15:0];
    endfunction

    function automatic logic [11:0] sat(input logic signed [15:0] v, input logic [11:0] hi);
        logic [11:0] r;
        if (v < 16'sh0000) begin
            r = CODE_MIN;
        end else if (v > signed'({4'h0, hi})) begin
            r = hi;
        end else begin
            r = v[11:0];
        end
        return r;
    endfunction

    function automatic logic [17:0] ramp_len(input logic [2:0] code);
        logic [17:0] c;
        unique case (code)
            3'h0: c = 18'(RAMP_C0);
            3'h1: c = 18'(RAMP_C1);
            3'h2: c = 18'(RAMP_C2);
            3'h3: c = 18'(RAMP_C3);
            3'h4: c = 18'(RAMP_C4);
            3'h5: c = 18'(RAMP_CYC_5);
            3'h6: c = 18'(RAMP_CYC_6);
            3'h7: c = 18'(RAMP_CYC_7);
        endcase
        return c;
    endfunction

    always_comb begin
        logic               tick;
        logic               odd;
        logic               share;
        logic               serve;
        logic               en;
        logic               gate;
        logic               fall;
        logic               rise;
        logic signed [15:0] base;
        logic signed [15:0] tadj;
        logic        [11:0] upper;
        logic        [11:0] goal;
        logic        [15:0] step_len;
        int                 ev;
        tick = 1'b0; odd = 1'b0; share = 1'b0; serve = 1'b0; en = 1'b0;
        gate = 1'b0; fall = 1'b0; rise = 1'b0;
        base = 16'sh0000; tadj = 16'sh0000; upper = CODE_MAX; goal = CODE_MIN;
        step_len = 16'h0000; ev = 0;
        n = q;
        n.active = 1'b1;
        // shared prescaler: every channel steps on the same tick
        tick = (q.ramp_cnt >= 18'(ramp_len(ramp_interval_code) - 18'h00001));
        n.ramp_cnt = tick ? 18'h00000 : 18'(q.ramp_cnt + 18'h00001);
        n.gate_prev = switch_gate_input;
        for (int i = 0; i < NCH; i++) begin
            odd   = (i % 2) == 1;
            ev    = i - (i % 2);
            serve = odd && (clamp_source_choice[i / 2] == SRC_ODD);
            share = odd && (track_enable[i] || serve);
            en    = share ? ch_enable[ev] : ch_enable[i];
            n.eff_en[i]  = en;
            n.eff_rng[i] = share ? ch_range[ev] : ch_range[i];
            n.eff_ofs[i] = share ? ch_offset[ev] : ch_offset[i];
            if (odd && track_enable[i]) begin
                base = signed'({4'h0, ch_value[ev]}) + 16'(signed'(track_offset[i]));
            end else begin
                base = signed'({4'h0, ch_value[i]});
            end
            tadj  = base;
            if (thermal_correction_on) begin
                tadj = base + tdelta(gradient_table[i], die_temperature);
            end
            upper = serve ? q.ramp[ev] : CODE_MAX;
            goal  = en ? sat(tadj, upper) : CODE_MIN;
            if (!en) begin
                n.ramp[i] = CODE_MIN;
            end else if (tick && q.ramp[i] < goal) begin
                n.ramp[i] = 12'(q.ramp[i] + 12'h001);
            end else if (tick && q.ramp[i] > goal) begin
                n.ramp[i] = 12'(q.ramp[i] - 12'h001);
            end
            gate = switch_gate_input[i / 4];
            fall = q.gate_prev[i / 4] && !gate;
            rise = !q.gate_prev[i / 4] && gate;
            step_len = (boost_slope[i] == 8'h00) ? 16'(FAST_CYC)
                     : 16'(boost_slope[i] * BOOST_STEP_CYC);
            if (odd || !boost_enable[i]) begin
                n.boost[i] = 8'h00;
                n.bcnt[i]  = 16'h0000;
                n.bdown[i] = 1'b0;
            end else if (!gate) begin
                n.bdown[i] = 1'b0;
                if (fall && q.bdown[i] && q.boost[i] != 8'h00) begin
                    n.boost[i] = boost_height[i];
                    n.bcnt[i]  = 16'h0000;
                end else if (q.boost[i] > boost_height[i]) begin
                    n.boost[i] = boost_height[i];
                end else if (q.boost[i] < boost_height[i]) begin
                    if (q.bcnt[i] >= 16'(FAST_CYC - 1)) begin
                        n.boost[i] = 8'(q.boost[i] + 8'h01);
                        n.bcnt[i]  = 16'h0000;
                    end else begin
                        n.bcnt[i] = 16'(q.bcnt[i] + 16'h0001);
                    end
                end
            end else if (rise) begin
                n.bdown[i] = 1'b1;
                n.bcnt[i]  = 16'h0000;
            end else if (q.boost[i] > boost_height[i]) begin
                n.boost[i] = boost_height[i];
            end else if (q.boost[i] != 8'h00) begin
                if (q.bcnt[i] >= 16'(step_len - 16'h0001)) begin
                    n.boost[i] = 8'(q.boost[i] - 8'h01);
                    n.bcnt[i]  = 16'h0000;
                end else begin
                    n.bcnt[i] = 16'(q.bcnt[i] + 16'h0001);
                end
            end
            n.word[i] = odd ? q.ramp[i]
                      : sat(signed'({4'h0, q.ramp[i]}) + signed'({8'h00, q.boost[i]}),
                            CODE_MAX);
        end
        for (int s = 0; s < 4; s++) begin
            n.clamped[s] = !switch_gate_input[s / 2] || output_force[s];
            n.drop[s]    = buffer_drop_code[s];
            if (!q.active) begin
                n.src[s] = SRC_RAIL;
            end else if (clamp_source_choice[s] == 2'h0) begin
                n.src[s] = SRC_RAIL;
            end else if (clamp_source_choice[s] == 2'h1) begin
                n.src[s] = SRC_ODD;
            end else begin
                n.src[s] = SRC_BUF;
            end
        end
        if (rb_write) begin
            n.rb_sel = rb_wdata[RB_SEL_LSB + 2 -: 3];
        end
        // read value follows the live word, so repeated reads track it
        n.rb_data = {1'b0, n.rb_sel, n.word[n.rb_sel]};
    end

    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rb_rdata             = q.rb_data;
    assign converter_input_word = q.word;
    assign eff_enable           = q.eff_en;
    assign eff_range            = q.eff_rng;
    assign eff_offset           = q.eff_ofs;
    assign out_clamped          = q.clamped;
    assign pinchoff_source      = q.src;
    assign clamp_buffer_drop    = q.drop;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_q);

    a_track_range: assert property (track_enable[3] |=> eff_range[3] == $past(ch_range[2]))
        else $error("tracking odd channel did not take even range");
    a_ramp_step: assert property (ch_enable[0] |=> (q.ramp[0] == $past(q.ramp[0])
        || q.ramp[0] == 12'($past(q.ramp[0]) + 12'h001)
        || q.ramp[0] == 12'($past(q.ramp[0]) - 12'h001)))
        else $error("ramp moved more than one count");
    a_disable_zero: assert property (!ch_enable[0] |=> q.ramp[0] == CODE_MIN)
        else $error("disabled channel ramp not zero");
    a_boost_cap: assert property (boost_enable[0] |=> q.boost[0] <= $past(boost_height[0]))
        else $error("boost above height");
    a_boost_restore: assert property (boost_enable[0] && q.gate_prev[0] && !switch_gate_input[0]
        && q.bdown[0] && q.boost[0] != 8'h00 |=> q.boost[0] == $past(boost_height[0]))
        else $error("boost not restored on gate fall");
    a_clamp_sel: assert property ((!switch_gate_input[0] || output_force[0]) |=> out_clamped[0])
        else $error("clamp not engaged");
    a_startup_rail: assert property (!q.active |=> pinchoff_source == '0)
        else $error("source not rail at startup");
    a_src_rail: assert property (q.active && clamp_source_choice[0] == 2'h0
        |=> pinchoff_source[0] == SRC_RAIL)
        else $error("choice 0 not rail");
    a_src_odd: assert property (q.active && clamp_source_choice[1] == 2'h1
        |=> pinchoff_source[1] == SRC_ODD)
        else $error("choice 1 not odd neighbour");
    a_src_buf: assert property (q.active && clamp_source_choice[2][1]
        |=> pinchoff_source[2] == SRC_BUF)
        else $error("choice 2 or 3 not buffer");
    a_rb_latch: assert property (rb_write |=> rb_rdata[14:12] == $past(rb_wdata[14:12]))
        else $error("readback selection not latched");
    a_rb_value: assert property (rb_rdata[11:0] == converter_input_word[rb_rdata[14:12]])
        else $error("readback value mismatch");

    c_boost_full: cover property (boost_enable[0] && q.boost[0] == boost_height[0]
        && boost_height[0] != 8'h00);
    c_boost_decay: cover property (q.bdown[0] && q.boost[0] == 8'h00 && boost_height[0] != 8'h00);
    c_ramp_goal: cover property (ch_enable[0] && q.ramp[0] != CODE_MIN && $stable(q.ramp[0]));
    c_rb_write: cover property (rb_write ##1 rb_rdata[14:12] == 3'h4);
endmodule

// ### bdvp_sysctl_model.sv
// system controller model: group switch pins and readback selection writes
`timescale 1ns/1ps
module bdvp_sysctl_model (
    input  wire logic        clock,
    output logic      [1:0]  switch_gate_input,
    output logic             rb_write,
    output logic      [15:0] rb_wdata
);
    initial begin
        switch_gate_input = 2'h3;
        rb_write = 1'b0;
        rb_wdata = 16'h0000;
    end
    // pins change between edges so the device samples clean levels
    task automatic set_gate(input int grp, input logic lvl);
        @(negedge clock);
        switch_gate_input[grp] = lvl;
    endtask
    // one-edge strobe; data is scrambled afterwards so nothing relies on stale bits
    task automatic write_sel(input logic grp, input logic [1:0] ch);
        @(negedge clock);
        rb_write = 1'b1;
        rb_wdata = {1'b0, grp, ch, 12'h000};
        @(negedge clock);
        rb_write = 1'b0;
        rb_wdata = ~rb_wdata;
    endtask
endmodule

// ### tb.sv
// self-checking testbench for the bias converter value pipeline
`timescale 1ns/1ps
module tb;
    import bdvp_pkg::*;
    logic             clock, rst_n, thermal_correction_on, rb_write;
    logic [7:0][11:0] ch_value, track_offset, converter_input_word;
    logic [7:0]       ch_enable, ch_range, track_enable, boost_enable, eff_enable, eff_range;
    logic [7:0][1:0]  ch_offset, eff_offset;
    logic [8:0]       die_temperature;
    logic [7:0][31:0] gradient_table;
    logic [2:0]       ramp_interval_code;
    logic [7:0][7:0]  boost_height, boost_slope;
    logic [1:0]       switch_gate_input;
    logic [3:0][1:0]  clamp_source_choice, pinchoff_source;
    logic [3:0][5:0]  buffer_drop_code, clamp_buffer_drop;
    logic [3:0]       output_force, out_clamped;
    logic [15:0]      rb_wdata, rb_rdata;
    int               error_cnt, num_checks;

    bdvp_top #(.RAMP_CYC_5(20), .RAMP_CYC_6(30), .RAMP_CYC_7(40), .BOOST_STEP_CYC(4)) uut (
        .clock(clock), .rst_n(rst_n), .ch_value(ch_value), .ch_enable(ch_enable),
        .ch_range(ch_range), .ch_offset(ch_offset), .track_enable(track_enable),
        .track_offset(track_offset), .thermal_correction_on(thermal_correction_on),
        .die_temperature(die_temperature), .gradient_table(gradient_table),
        .ramp_interval_code(ramp_interval_code), .boost_enable(boost_enable),
        .boost_height(boost_height), .boost_slope(boost_slope),
        .switch_gate_input(switch_gate_input), .clamp_source_choice(clamp_source_choice),
        .buffer_drop_code(buffer_drop_code), .output_force(output_force),
        .rb_write(rb_write), .rb_wdata(rb_wdata), .rb_rdata(rb_rdata),
        .converter_input_word(converter_input_word), .eff_enable(eff_enable),
        .eff_range(eff_range), .eff_offset(eff_offset), .out_clamped(out_clamped),
        .pinchoff_source(pinchoff_source), .clamp_buffer_drop(clamp_buffer_drop));
    bdvp_sysctl_model ctl (.clock(clock), .switch_gate_input(switch_gate_input),
        .rb_write(rb_write), .rb_wdata(rb_wdata));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_true(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask
    // bounded wait for a word, then a strict compare
    task automatic wait_word(input int ch, input logic [11:0] exp, input int lim, input string m);
        int n;
        n = 0;
        while (converter_input_word[ch] !== exp && n < lim) begin
            @(negedge clock);
            n++;
        end
        chk_eq({4'h0, converter_input_word[ch]}, {4'h0, exp}, m);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_track;
        @(negedge clock);
        ch_enable = 8'h0C;
        ch_value[2] = 12'h040;
        ch_range = 8'h04;
        ch_offset[2] = 2'h2;
        track_enable[3] = 1'b1;
        track_offset[3] = 12'hFF0;
        repeat (6) @(negedge clock);
        chk_true(converter_input_word[2] < 12'h005, "no ramp from zero");
        wait_word(2, 12'h040, 200, "even ramp end");
        wait_word(3, 12'h030, 200, "tracking odd value");
        chk_eq({8'h00, eff_range}, 16'h000C, "tracking range");
        chk_eq({14'h0, eff_offset[3]}, 16'h0002, "tracking offset");
        ctl.write_sel(1'b0, 2'h3);
        @(negedge clock);
        chk_eq(rb_rdata, 16'h3030, "readback odd A3");
        $display("test track done");
    endtask

    task automatic t_limit;
        @(negedge clock);
        ch_value[2] = 12'hFF0;
        track_offset[3] = 12'h020;
        wait_word(3, 12'hFFF, 9000, "upper saturation");
        clamp_source_choice[1] = 2'h1;
        track_enable[3] = 1'b0;
        ch_enable[3] = 1'b0;
        // own value above the even word, so only the limit can hold it
        ch_value[3] = 12'hFFF;
        wait_word(3, 12'hFF0, 100, "odd limited by even");
        chk_eq({8'h00, eff_enable}, 16'h000C, "source odd uses even enable");
        chk_eq({14'h0, pinchoff_source[1]}, 16'h0001, "odd source");
        chk_eq({8'h00, eff_range}, 16'h000C, "source odd uses even range");
        clamp_source_choice[1] = 2'h0;
        $display("test limit done");
    endtask

    task automatic t_thermal;
        @(negedge clock);
        ch_enable[4] = 1'b1;
        ch_value[4] = 12'h100;
        gradient_table[4] = 32'h7000_0000;
        die_temperature = 9'h08D;
        thermal_correction_on = 1'b1;
        wait_word(4, 12'h100, 600, "zero delta at reference");
        die_temperature = 9'h035;
        wait_word(4, 12'h0EA, 100, "gradient 0 in top nibble");
        gradient_table[4] = 32'h7777_7777;
        die_temperature = 9'h0AD;
        wait_word(4, 12'h115, 200, "one segment of +7");
        ch_value[4] = 12'h005;
        die_temperature = 9'h035;
        wait_word(4, 12'h000, 600, "lower saturation");
        thermal_correction_on = 1'b0;
        wait_word(4, 12'h005, 100, "no delta when off");
        ctl.write_sel(1'b1, 2'h0);
        @(negedge clock);
        chk_eq(rb_rdata, 16'h4005, "readback B0");
        $display("test thermal done");
    endtask

    task automatic t_rate;
        int iv[8];
        int n;
        logic [11:0] w;
        iv = '{RAMP_C0, RAMP_C1, RAMP_C2, RAMP_C3, RAMP_C4, 20, 30, 40};
        for (int c = 0; c < 8; c++) begin
            @(negedge clock);
            ramp_interval_code = 3'(c);
            ch_value[4] = ch_value[4] + 12'h003;
            w = converter_input_word[4];
            n = 0;
            while (converter_input_word[4] === w && n < 9000) begin
                @(negedge clock);
                n++;
            end
            w = converter_input_word[4];
            n = 0;
            while (converter_input_word[4] === w && n < 9000) begin
                @(negedge clock);
                n++;
            end
            chk_eq(n[15:0], iv[c][15:0], "ramp step interval");
        end
        ramp_interval_code = 3'h0;
        $display("test rate done");
    endtask

    task automatic t_boost;
        @(negedge clock);
        ch_enable[0] = 1'b1;
        ch_value[0] = 12'h100;
        boost_enable[0] = 1'b1;
        wait_word(0, 12'h100, 600, "base value");
        ctl.set_gate(0, 1'b0);
        repeat (2) @(negedge clock);
        chk_eq({15'h0, out_clamped[0]}, 16'h0001, "clamped on gate low");
        wait_word(0, 12'h108, 24, "boost rise");
        ctl.set_gate(0, 1'b1);
        repeat (10) @(negedge clock);
        chk_true(converter_input_word[0] < 12'h108, "decay started");
        ctl.set_gate(0, 1'b0);
        repeat (2) @(negedge clock);
        chk_eq({4'h0, converter_input_word[0]}, 16'h0108, "restore height");
        ctl.set_gate(0, 1'b1);
        repeat (20) @(negedge clock);
        chk_true(converter_input_word[0] > 12'h100, "slow decay");
        wait_word(0, 12'h100, 20, "decay end");
        boost_slope[0] = 8'h00;
        ctl.set_gate(0, 1'b0);
        wait_word(0, 12'h108, 24, "boost rise again");
        ctl.set_gate(0, 1'b1);
        wait_word(0, 12'h100, 20, "fast decay");
        output_force[0] = 1'b1;
        repeat (2) @(negedge clock);
        chk_eq({15'h0, out_clamped[0]}, 16'h0001, "forced clamp");
        output_force[0] = 1'b0;
        repeat (2) @(negedge clock);
        chk_eq({15'h0, out_clamped[0]}, 16'h0000, "released clamp");
        $display("test boost done");
    endtask

    task automatic t_source;
        logic [1:0] exp_src[4];
        exp_src = '{2'h0, 2'h1, 2'h2, 2'h2};
        for (int c = 0; c < 4; c++) begin
            @(negedge clock);
            clamp_source_choice[2] = 2'(c);
            buffer_drop_code[2] = 6'h2A;
            repeat (2) @(negedge clock);
            chk_eq({14'h0, pinchoff_source[2]}, {14'h0, exp_src[c]}, "source");
            chk_eq({10'h0, clamp_buffer_drop[2]}, 16'h002A, "drop code");
        end
        $display("test source done");
    endtask

    initial begin
        error_cnt = 0;
        num_checks = 0;
        rst_n = 1'b0;
        ch_value = '0;
        track_offset = '0;
        ch_enable = 8'h00;
        ch_range = 8'h00;
        ch_offset = '0;
        track_enable = 8'h00;
        thermal_correction_on = 1'b0;
        die_temperature = 9'h08D;
        gradient_table = '0;
        ramp_interval_code = 3'h0;
        boost_enable = 8'h00;
        boost_height = {8{8'h08}};
        boost_slope = {8{8'h01}};
        clamp_source_choice = {4{2'h2}};
        buffer_drop_code = '0;
        output_force = 4'h0;
        repeat (8) @(negedge clock);
        chk_eq({14'h0, pinchoff_source[0]}, 16'h0000, "rail during reset");
        chk_eq(rb_rdata, 16'h0000, "readback in reset");
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        clamp_source_choice = '0;
        t_track();
        t_limit();
        t_thermal();
        t_rate();
        t_boost();
        t_source();
        report_and_stop();
    end

    // the longest paths are the saturation ramp and rate code 4
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end
endmodule
